// >>> adrb_defines.vh
// Constants for the conversion result register bank of channels 5 to 9
`ifndef ADRB_DEFINES_VH
`define ADRB_DEFINES_VH

// Register indexes; the byte address on the bus is four times the index
`define ADRB_IDX_CH5_LOW 14'h12AA
`define ADRB_IDX_CH5_HIGH 14'h12AB
`define ADRB_IDX_CH6_LOW 14'h12AC
`define ADRB_IDX_CH6_HIGH 14'h12AD
`define ADRB_IDX_CH7_LOW 14'h12AE
`define ADRB_IDX_CH7_HIGH 14'h12AF
`define ADRB_IDX_CH8_LOW 14'h12B0
`define ADRB_IDX_CH8_HIGH 14'h12B1
`define ADRB_IDX_CH9_LOW 14'h12B2
`define ADRB_IDX_CH9_HIGH 14'h12B3
// Interrupt status and mask registers
`define ADRB_IDX_IRQ_STATUS 14'h12B8
`define ADRB_IDX_IRQ_MASK 14'h12B9

// Channel numbering and count
`define ADRB_NUM_CH 5
`define ADRB_FIRST_CH 4'h5
`define ADRB_LAST_CH 4'h9

// Result and field layout
`define ADRB_RES_W 10
`define ADRB_HIGH_MSB 9
`define ADRB_HIGH_LSB 2
`define ADRB_LOW_MSB 1
`define ADRB_LOW_LSB 0
`define ADRB_LOW_ONES 5'h1F
`define ADRB_RES_RESET 10'h000
`define ADRB_FLAG_RESET 1'h0
`define ADRB_IRQ_RESET 5'h00

// Bus address split
`define ADRB_ADDR_IDX_MSB 15
`define ADRB_ADDR_IDX_LSB 2
`define ADRB_ADDR_TOP_ZERO 16'h0000
`define ADRB_ADDR_LOW_ZERO 2'h0

// Bus responses
`define ADRB_RESP_OKAY 2'h0
`define ADRB_RESP_SLVERR 2'h2

`endif

// >>> adrb_result_bank.v
// Conversion result register bank for channels 5 to 9 with an AXI4-Lite slave
//
// Notes on behaviour
// - High byte holds result bits 9 to 2
// - Low byte bits 7,6 hold result bits 1,0
// - Low byte bit 0 is stored flag, reset 0
// - Storing a new result sets the flag
// - Reading either byte clears the flag
// - Low byte bits 5 to 1 read as one
// - Results are 10-bit codes, 1024 steps
//
// Register bus
// - Byte address is four times the register index; data sits in bits 7:0
// - Address and data may come in either order; the answer follows both
// - Only aligned words of the low 64 KiB decode; all else is a slave error
// - One read and one write at a time; no queue behind either answer
// - Writes to result registers are accepted with OKAY and have no effect
//
// Timing
// - Read answer stands from the same edge that takes the address
// - Write answer comes one edge after address and data are both held
// - Each answer stands until the master takes it
//
// Converter side
// - A store is a one-cycle strobe with channel number and code
// - Channel numbers outside 5 to 9 are ignored
// - No back-pressure: a new store simply overwrites the old code
// - A store and a read of one channel in the same cycle leave the flag set,
//   so a result that lands during the read is never lost
//
// Interrupt
// - Each store sets a sticky status bit, cleared by writing a one
// - A store in the cycle of the clearing write wins
// - A mask bit of the same layout lets the bit raise the level output
//
// Reset
// - Results, flags, status and mask all start at zero
// - The bus takes a request at the first edge after release
//
// Limitations
// - Only the lowest write strobe is looked at
// - Protection bits are ignored
`timescale 1ns/100ps
`include "adrb_defines.vh"

module adrb_result_bank (
    // Clock and reset
    input wire clock,
    input wire rst_n,
    // Converter core result port
    input wire conv_valid,
    input wire [3:0] conv_channel,
    input wire [9:0] conv_result,
    // AXI4-Lite write address channel
    input wire [31:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // AXI4-Lite write data channel
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response channel
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address channel
    input wire [31:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // AXI4-Lite read data channel
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Interrupt
    output wire irq
);

    // Per-channel result storage and flags
    reg [9:0] result_q [0:4];
    reg [4:0] stored_flag_q;
    reg [4:0] irq_status_q;
    reg [4:0] irq_mask_q;

    // Write channel holding registers
    reg aw_held_q;
    reg [31:0] aw_addr_q;
    reg w_held_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;

    // Read decode results
    reg [31:0] rd_data_d;
    reg rd_hit_d;
    reg [4:0] rd_clear_d;

    // Write decode results
    reg wr_hit_d;
    reg wr_status_d;
    reg wr_mask_d;

    wire [4:0] store_hit;
    wire rd_take;
    wire wr_fire;
    wire [13:0] rd_idx;
    wire rd_aligned;
    wire [13:0] wr_idx;
    wire wr_aligned;

    // Handshakes: one address/data held each, response only when both are in
    assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held_q & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    assign rd_take = s_axi_arvalid & s_axi_arready;
    assign wr_fire = aw_held_q & w_held_q & ~s_axi_bvalid;

    // Address split; anything outside the aligned low 64 KiB is unmapped
    wire rd_top_ok;
    wire rd_low_ok;
    wire wr_top_ok;
    wire wr_low_ok;
    assign rd_idx = s_axi_araddr[`ADRB_ADDR_IDX_MSB:`ADRB_ADDR_IDX_LSB];
    assign rd_top_ok = (s_axi_araddr[31:16] == `ADRB_ADDR_TOP_ZERO);
    assign rd_low_ok = (s_axi_araddr[1:0] == `ADRB_ADDR_LOW_ZERO);
    assign rd_aligned = rd_top_ok && rd_low_ok;

    // Write address checks use the held copy, not the live bus
    assign wr_idx = aw_addr_q[`ADRB_ADDR_IDX_MSB:`ADRB_ADDR_IDX_LSB];
    assign wr_top_ok = (aw_addr_q[31:16] == `ADRB_ADDR_TOP_ZERO);
    assign wr_low_ok = (aw_addr_q[1:0] == `ADRB_ADDR_LOW_ZERO);
    assign wr_aligned = wr_top_ok && wr_low_ok;

    // Per-channel decode results gathered from the slices below
    wire [4:0] rd_low_hit;
    wire [4:0] rd_high_hit;
    wire [4:0] clear_hit;
    wire [4:0] status_clear;
    wire [4:0] pending;
    wire [39:0] low_byte_all;
    wire [39:0] high_byte_all;
    wire rd_status_hit;
    wire rd_mask_hit;
    wire wr_clear_ok;

    // Write-one-to-clear only for a completed write with the low strobe set
    assign wr_clear_ok = wr_fire && wr_status_d && w_strb_q[0];

    // One storage slice per channel
    genvar gc;
    generate
        for (gc = 0; gc < `ADRB_NUM_CH; gc = gc + 1) begin : g_ch
            // Slice position as a plain integer so its bits can be picked
            localparam integer CH_OFS = gc;
            // Converter addresses channels by their real number, 5 to 9
            localparam [3:0] CH_NUM = `ADRB_FIRST_CH + CH_OFS[3:0];
            // Low and high indexes step by two from one channel to the next
            localparam [13:0] LOW_IDX = `ADRB_IDX_CH5_LOW + {CH_OFS[12:0], 1'b0};
            localparam [13:0] HIGH_IDX = `ADRB_IDX_CH5_HIGH + {CH_OFS[12:0], 1'b0};

            // A store for any other channel number is ignored
            assign store_hit[gc] = conv_valid && (conv_channel == CH_NUM);

            // Both bytes load in the cycle the flag sets; held otherwise
            always @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    result_q[gc] <= `ADRB_RES_RESET;
                end else if (store_hit[gc]) begin
                    result_q[gc] <= conv_result;
                end
            end

            // Address match for the two bytes of this channel
            assign rd_low_hit[gc] = rd_aligned && (rd_idx == LOW_IDX);
            assign rd_high_hit[gc] = rd_aligned && (rd_idx == HIGH_IDX);

            // Flag clears only when the read is actually taken, not while it waits
            assign clear_hit[gc] = rd_take && (rd_low_hit[gc] || rd_high_hit[gc]);

            // Set wins over a read clear in the same cycle so no result is missed
            always @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    stored_flag_q[gc] <= `ADRB_FLAG_RESET;
                end else if (store_hit[gc]) begin
                    stored_flag_q[gc] <= 1'b1;
                end else if (rd_clear_d[gc]) begin
                    stored_flag_q[gc] <= 1'b0;
                end
            end

            // Low byte: two result bits, five constant ones, then the flag
            assign low_byte_all[gc*8 +: 8] = {result_q[gc][`ADRB_LOW_MSB:`ADRB_LOW_LSB],
                                              `ADRB_LOW_ONES,
                                              stored_flag_q[gc]};

            // High byte: upper eight result bits, bit 9 on top
            assign high_byte_all[gc*8 +: 8] = result_q[gc][`ADRB_HIGH_MSB:`ADRB_HIGH_LSB];

            // Write data bit of this channel in a status write
            assign status_clear[gc] = wr_clear_ok && w_data_q[gc];

            // Sticky event bit; write one to clear, new event wins
            always @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    irq_status_q[gc] <= 1'b0;
                end else if (store_hit[gc]) begin
                    irq_status_q[gc] <= 1'b1;
                end else if (status_clear[gc]) begin
                    irq_status_q[gc] <= 1'b0;
                end
            end

            // Event counts toward the interrupt only while its mask bit is set
            assign pending[gc] = irq_status_q[gc] && irq_mask_q[gc];
        end
    endgenerate

    // Any unmasked stored-result event raises the level interrupt
    assign irq = |pending;

    // Status and mask registers share the same address check as the results
    assign rd_status_hit = rd_aligned && (rd_idx == `ADRB_IDX_IRQ_STATUS);
    assign rd_mask_hit = rd_aligned && (rd_idx == `ADRB_IDX_IRQ_MASK);

    // Read decode: pick the register and note which flag the read clears
    integer i;
    always @* begin
        rd_data_d = 32'h0000_0000;
        rd_hit_d = (|rd_low_hit) || (|rd_high_hit) || rd_status_hit || rd_mask_hit;
        rd_clear_d = clear_hit;
        // Only one index can match, so the order of these tests does not matter
        for (i = 0; i < `ADRB_NUM_CH; i = i + 1) begin
            if (rd_low_hit[i]) begin
                rd_data_d[7:0] = low_byte_all[i*8 +: 8];
            end
            if (rd_high_hit[i]) begin
                rd_data_d[7:0] = high_byte_all[i*8 +: 8];
            end
        end
        if (rd_status_hit) begin
            rd_data_d[4:0] = irq_status_q;
        end
        if (rd_mask_hit) begin
            rd_data_d[4:0] = irq_mask_q;
        end
    end

    // Read answer code: unmapped or misaligned addresses get a slave error
    wire [1:0] rd_resp_d;
    assign rd_resp_d = rd_hit_d ? `ADRB_RESP_OKAY : `ADRB_RESP_SLVERR;

    // Read valid; drops at the edge where the master takes the data
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
        end else if (rd_take) begin
            s_axi_rvalid <= 1'b1;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Read data and code registered so they stand until taken
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `ADRB_RESP_OKAY;
        end else if (rd_take) begin
            s_axi_rdata <= rd_data_d;
            s_axi_rresp <= rd_resp_d;
        end
    end

    // Write decode; result registers are read-only and writes to them are ignored
    always @* begin
        wr_status_d = wr_aligned && (wr_idx == `ADRB_IDX_IRQ_STATUS);
        wr_mask_d = wr_aligned && (wr_idx == `ADRB_IDX_IRQ_MASK);
        wr_hit_d = wr_status_d || wr_mask_d ||
                   (wr_aligned && (wr_idx >= `ADRB_IDX_CH5_LOW) && (wr_idx <= `ADRB_IDX_CH9_HIGH));
    end

    // Channel takes, each on its own valid and ready
    wire aw_take;
    wire w_take;
    wire [1:0] wr_resp_d;
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign wr_resp_d = wr_hit_d ? `ADRB_RESP_OKAY : `ADRB_RESP_SLVERR;

    // Write address is held until the data has come as well
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= 32'h0000_0000;
        end else if (aw_take) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held_q <= 1'b0;
        end
    end

    // Write data and strobes are held until the address has come as well
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            w_held_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else if (w_take) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_q <= 1'b0;
        end
    end

    // Write response; one write at a time, so no response is ever queued
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ADRB_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_resp_d;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Mask register; only the lowest strobe carries its bits
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask_q <= `ADRB_IRQ_RESET;
        end else if (wr_fire && wr_mask_d && w_strb_q[0]) begin
            irq_mask_q <= w_data_q[4:0];
        end
    end

endmodule

// >>> adrb_assertions.sv
// Checker for the result bank bus answers and stored results
`timescale 1ns/100ps
module adrb_checker (
    // Clock, reset, converter
    input wire clock, input wire rst_n, input wire conv_valid, input wire [3:0] conv_channel,
    input wire [9:0] conv_result,
    // Register bus
    input wire [31:0] s_axi_araddr, input wire s_axi_arvalid, input wire s_axi_arready,
    input wire s_axi_rvalid, input wire [31:0] s_axi_rdata,
    input wire s_axi_awready, input wire s_axi_wready, input wire s_axi_bvalid
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Decoded result read and valid store; pair index is address bits 7:3
    wire [4:0] ra = s_axi_araddr[7:3];
    wire hit = s_axi_arvalid && s_axi_arready && s_axi_araddr[31:8] == 24'h4A && s_axi_araddr[1:0] == 2'h0
        && ra >= 5'h15 && ra <= 5'h19;
    wire lo = !s_axi_araddr[2];
    wire cv = conv_valid && conv_channel >= 4'h5 && conv_channel <= 4'h9;
    wire [4:0] cc = {1'b0, conv_channel} + 5'h10;
    reg [31:0] fl_q;
    reg [4:0] ch_q;
    reg [9:0] res_q;
    reg [7:0] ex_q;
    // Expected flags; a store in the read edge wins over the clear
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            fl_q <= 32'h0;
            ch_q <= 5'h0;
            res_q <= 10'h0;
            ex_q <= 8'h0;
        end else begin
            fl_q <= (fl_q & ~(hit ? 32'h1 << ra : 32'h0)) | (cv ? 32'h1 << cc : 32'h0);
            ch_q <= cv ? cc : ch_q;
            res_q <= cv ? conv_result : res_q;
            ex_q <= lo ? {res_q[1:0], 5'h1F, fl_q[ra]} : res_q[9:2];
        end
    end
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
    low_ones_a: assert property (hit && lo |=> s_axi_rdata[31:8] == 24'h0 && s_axi_rdata[5:1] == 5'h1F)
        else $error("low ones wrong");
    flag_a: assert property (hit && lo |=> s_axi_rdata[0] == ex_q[0]) else $error("flag wrong");
    high_data_a: assert property (hit && !lo && ra == ch_q && !cv |=> s_axi_rdata == {24'h0, ex_q})
        else $error("high byte wrong");
    low_data_a: assert property (hit && lo && ra == ch_q && !cv |=> s_axi_rdata[7:6] == ex_q[7:6])
        else $error("low bits wrong");
    wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write not held");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read not held");
    rd_stand_a: assert property (s_axi_rvalid |-> $past(s_axi_arvalid) || $past(s_axi_rvalid)) else $error("stray rvalid");
    cover property (hit && !lo);
    cover property (cv);
    cover property (s_axi_bvalid);
endmodule
bind adrb_result_bank adrb_checker i_adrb_checker (.*);

// >>> adrb_conv_model.sv
// Converter core stand-in handing finished results to the bank
`timescale 1ns/100ps
module adrb_conv_model (
    // Request from the bench
    input wire clock, input wire go, input wire [3:0] ch_in, input wire [9:0] res_in,
    // Result strobe toward the bank
    output reg conv_valid, output reg [3:0] conv_channel, output reg [9:0] conv_result
);
    initial {conv_valid, conv_channel, conv_result} = 15'h0;
    // One-cycle strobe; outside it the lines toggle so stale data is never leaned on
    always @(posedge clock) begin
        conv_valid <= go;
        conv_channel <= go ? ch_in : ~conv_channel;
        conv_result <= go ? res_in : ~conv_result;
    end
endmodule

// >>> adrb_result_bank_tb.sv
// Self-checking bench for the result register bank
`timescale 1ns/100ps
module adrb_result_bank_tb;
    reg clock = 0, rst_n = 0, go = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    reg s_axi_arvalid = 0, s_axi_rready = 0;
    reg [3:0] ch_in = 0, s_axi_wstrb = 0;
    reg [9:0] res_in = 0;
    reg [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, lf = 32'hD85C;
    wire conv_valid, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    wire [3:0] conv_channel;
    wire [9:0] conv_result;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    integer error_cnt = 0, num_checks = 0, n, i;
    reg [33:0] q[$];
    reg [9:0] rv[5:9];
    initial forever #5 clock = ~clock;
    adrb_conv_model i_adrb_conv_model (.*);
    adrb_result_bank i_adrb_result_bank (.*, .s_axi_awprot(3'h0), .s_axi_arprot(3'h0));
    task chk(input [8*5:1] nm, input [33:0] s, e);
        begin
            num_checks = num_checks + 1;
            if (s !== e) begin
                error_cnt = error_cnt + 1;
                $display("[FAIL] %0s exp %h got %h", nm, e, s);
            end
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d mismatches %0d", num_checks, error_cnt);
            if (error_cnt == 0 && num_checks > 0) $display("Test passed");
            else $display("Test failed");
            $finish;
        end
    endtask
    // Bounded wait of one edge; running out ends the run
    task tick;
        begin
            @(posedge clock);
            n = n + 1;
            if (n > 40) begin
                error_cnt = error_cnt + 1;
                finish_test;
            end
        end
    endtask
    function [31:0] lfsr(input [31:0] v);
        lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // Handshakes are judged on values settled before the edge that takes them
    task rd(input [31:0] a, input [33:0] e);
        reg ar_seen, r_seen;
        begin
            @(posedge clock);
            n = 0;
            q.push_back(e);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1;
            s_axi_rready <= 1;
            do begin
                @(negedge clock);
                ar_seen = s_axi_arvalid && s_axi_arready;
                r_seen = s_axi_rvalid;
                tick;
                if (ar_seen) s_axi_arvalid <= 0;
            end while (!r_seen);
            s_axi_rready <= 0;
        end
    endtask
    task wr(input [31:0] a, d, input [1:0] e);
        reg aw_seen, w_seen, b_seen;
        reg [1:0] br;
        begin
            @(posedge clock);
            n = 0;
            {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hF};
            {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
            do begin
                @(negedge clock);
                aw_seen = s_axi_awvalid && s_axi_awready;
                w_seen = s_axi_wvalid && s_axi_wready;
                b_seen = s_axi_bvalid;
                br = s_axi_bresp;
                tick;
                if (aw_seen) s_axi_awvalid <= 0;
                if (w_seen) s_axi_wvalid <= 0;
            end while (!b_seen);
            s_axi_bready <= 0;
            chk("bresp", {32'h0, br}, {32'h0, e});
        end
    endtask
    // Store a result; the wait lets the strobe land before any read
    task st(input [3:0] c, input [9:0] r);
        begin
            @(posedge clock);
            {ch_in, res_in, go} <= {c, r, 1'b1};
            @(posedge clock);
            go <= 0;
            rv[c] = r;
            repeat (2) @(posedge clock);
        end
    endtask
    // Read results are compared against the oldest note
    always @(negedge clock) if (s_axi_rvalid && s_axi_rready) chk("read", {s_axi_rresp, s_axi_rdata}, q.pop_front());
    initial begin
        repeat (5) @(posedge clock);
        rst_n <= 1;
        for (i = 5; i < 10; i = i + 1) rd(32'h4A80 + 8 * i, {2'h0, 32'h3E});
        $display("reset test done");
        for (i = 5; i < 10; i = i + 1) begin
            lf = lfsr(lf);
            st(i[3:0], i == 5 ? 10'h3FF : i == 9 ? 10'h000 : lf[9:0]);
            rd(32'h4A80 + 8 * i, {26'h0, rv[i][1:0], 6'h3F});
            rd(32'h4A84 + 8 * i, {26'h0, rv[i][9:2]});
            rd(32'h4A80 + 8 * i, {26'h0, rv[i][1:0], 6'h3E});
        end
        st(4'h7, 10'h2A5);
        rd(32'h4AB8, {26'h0, 8'h7F});
        rd(32'h4AB8, {26'h0, 8'h7E});
        $display("channel test done");
        chk("irq", {33'h0, irq}, 34'h0);
        wr(32'h4AE4, 32'h1F, 2'h0);
        chk("irq", {33'h0, irq}, 34'h1);
        rd(32'h4AE4, {2'h0, 32'h1F});
        wr(32'h4AE0, 32'h1F, 2'h0);
        chk("irq", {33'h0, irq}, 34'h0);
        wr(32'h4AAC, 32'h55, 2'h0);
        rd(32'h4AAC, {26'h0, rv[5][9:2]});
        rd(32'h4AD0, {2'h2, 32'h0});
        wr(32'h4AA9, 32'h0, 2'h2);
        $display("bus test done");
        finish_test;
    end
endmodule
